// >>> logic/unh_port.sv
// Device end of the umbilical byte and nibble handshake port
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - The port raises port_acknowledge once the host byte is captured.
// - The port drops port_acknowledge once the processor reads the byte.
// - port_request_n is low while a byte waits for the host, else high.
// - The port shows the high nibble on select low and the low on high.
// - On host_acknowledge high the port raises port_request_n, unless a new byte is written in that cycle.
module unh_port
	import unh_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire unh_host_pins_t host_pins,
	output logic [7:0] host_input_word,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic irq
);

	//////////////////////////////////////////////////////////////////////////
	// Three-stage synchronisers; stage one feeds only stage two
	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [10:0] sync3;
	logic req_f;
	logic ack_f;
	logic sel_f;
	logic req_q;
	logic ack_q;
	logic [7:0] rx_data;
	logic rx_full;
	logic [7:0] tx_data;
	logic tx_pending;
	logic req_evt;
	logic ack_evt;
	logic req_rise;
	logic ack_rise;
	logic rx_take;
	logic tx_load;
	logic st_write;
	logic [7:0] next_rdata;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= host_pins;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Control lines change only when stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			req_f <= 1'b0;
			ack_f <= 1'b0;
			sel_f <= 1'b0;
		end else begin
			if (sync2[2] == sync3[2]) req_f <= sync3[2];
			if (sync2[1] == sync3[1]) ack_f <= sync3[1];
			if (sync2[0] == sync3[0]) sel_f <= sync3[0];
		end
	end

	// Edge detection on the filtered levels
	always_ff @(posedge clk) begin
		if (rst) begin
			req_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			req_q <= req_f;
			ack_q <= ack_f;
		end
	end

	assign req_rise = req_f & ~req_q;
	assign ack_rise = ack_f & ~ack_q;
	assign rx_take = reg_read && reg_addr == UNH_REG_RX_DATA;
	assign tx_load = reg_write && reg_addr == UNH_REG_TX_DATA;
	assign st_write = reg_write && reg_addr == UNH_REG_STATUS;

	//////////////////////////////////////////////////////////////////////////
	// Host to processor: capture on request rise, held until read.
	// Data is stable before the request, and the request takes longer
	// through its filter than the data does, so stage three is safe.
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_data <= UNH_DATA_RST;
			rx_full <= 1'b0;
		end else if (req_rise && !rx_full) begin
			rx_data <= sync3[10:3];
			rx_full <= 1'b1;
		end else if (rx_take) begin
			rx_full <= 1'b0;
		end
	end

	// Processor to host: a new write wins over a same-cycle acknowledge
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_data <= UNH_DATA_RST;
			tx_pending <= 1'b0;
		end else if (tx_load) begin
			tx_data <= reg_wdata;
			tx_pending <= 1'b1;
		end else if (ack_rise) begin
			tx_pending <= 1'b0;
		end
	end

	// Host input word, registered; unused upper bits read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			host_input_word <= UNH_HIW_RST;
		end else begin
			host_input_word[7:6] <= 2'h0;
			host_input_word[UNH_HIW_ACK] <= rx_full;
			host_input_word[UNH_HIW_REQ_N] <= ~tx_pending;
			host_input_word[3:0] <= sel_f ? tx_data[3:0] : tx_data[7:4];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Sticky handshake events; a new edge wins over a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			req_evt <= 1'b0;
			ack_evt <= 1'b0;
		end else begin
			if (req_rise) req_evt <= 1'b1;
			else if (st_write && reg_wdata[UNH_ST_REQ_EVT]) req_evt <= 1'b0;
			if (ack_rise) ack_evt <= 1'b1;
			else if (st_write && reg_wdata[UNH_ST_ACK_EVT]) ack_evt <= 1'b0;
		end
	end

	assign irq = req_evt | ack_evt;

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			UNH_REG_RX_DATA: next_rdata = rx_data;
			UNH_REG_TX_DATA: next_rdata = tx_data;
			UNH_REG_STATUS: begin
				next_rdata[UNH_ST_RX_FULL] = rx_full;
				next_rdata[UNH_ST_TX_PEND] = tx_pending;
				next_rdata[UNH_ST_REQ_EVT] = req_evt;
				next_rdata[UNH_ST_ACK_EVT] = ack_evt;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) reg_rdata <= 8'h00;
		else if (reg_read) reg_rdata <= next_rdata;
		else reg_rdata <= 8'h00;
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence tx_write_s;
		reg_write && reg_addr == UNH_REG_TX_DATA;
	endsequence

	sequence host_ack_s;
		ack_rise && !(reg_write && reg_addr == UNH_REG_TX_DATA);
	endsequence

	rx_capture_a: assert property (req_rise && !rx_full |=>
		rx_full && rx_data == $past(sync3[10:3]))
		else $error("host byte not captured");
	ack_pin_a: assert property (rx_full && !rx_take |=>
		##1 host_input_word[UNH_HIW_ACK])
		else $error("port acknowledge not shown");
	rx_release_a: assert property (rx_take && rx_full |=> !rx_full ##1
		!host_input_word[UNH_HIW_ACK] || rx_full)
		else $error("acknowledge not dropped after read");
	req_low_a: assert property (tx_write_s |=>
		tx_pending ##1 !host_input_word[UNH_HIW_REQ_N])
		else $error("byte waiting but request high");
	nibble_high_a: assert property (!sel_f |=>
		host_input_word[3:0] == $past(tx_data[7:4]))
		else $error("high nibble wrong");
	nibble_low_a: assert property (sel_f |=>
		host_input_word[3:0] == $past(tx_data[3:0]))
		else $error("low nibble wrong");
	consume_a: assert property (host_ack_s |=> !tx_pending ##1
		host_input_word[UNH_HIW_REQ_N] || tx_pending)
		else $error("request not raised after host acknowledge");
	// Firmware may clear the flag one cycle after it is set
	irq_event_a: assert property ((req_rise || ack_rise) |=>
		irq ##1 (irq || $past(st_write)))
		else $error("handshake edge raised no interrupt");
	hiw_flags_a: assert property (1'b1 |=>
		host_input_word[UNH_HIW_ACK] == $past(rx_full) &&
		host_input_word[UNH_HIW_REQ_N] == !$past(tx_pending))
		else $error("acknowledge or request pin stale");
	rdata_idle_a: assert property (!reg_read |=>
		reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	sync_agree_a: assert property ($changed(req_f) |->
		$past(sync2[2]) == $past(sync3[2]) && req_f == $past(sync3[2]))
		else $error("request changed before synchronisers agreed");
endmodule

// >>> include/unh_pkg.sv
// Constants and types for the umbilical nibble handshake port
package unh_pkg;
	// Register indices on the local register port
	localparam logic [3:0] UNH_REG_RX_DATA = 4'h0;
	localparam logic [3:0] UNH_REG_TX_DATA = 4'h1;
	localparam logic [3:0] UNH_REG_STATUS = 4'h2;
	// Status register bit positions
	localparam int UNH_ST_RX_FULL = 0;
	localparam int UNH_ST_TX_PEND = 1;
	localparam int UNH_ST_REQ_EVT = 2;
	localparam int UNH_ST_ACK_EVT = 3;
	// Host input word bit positions
	localparam int UNH_HIW_REQ_N = 4;
	localparam int UNH_HIW_ACK = 5;
	// Reset values
	localparam logic [7:0] UNH_DATA_RST = 8'h00;
	localparam logic [7:0] UNH_HIW_RST = 8'h10;
	// Pins driven by the host, asynchronous to clk
	typedef struct packed {
		logic [7:0] data;
		logic host_request;
		logic host_acknowledge;
		logic nibble_select;
	} unh_host_pins_t;
endpackage

// >>> tb/unh_host_model.sv
// Host computer model polling the handshake lines
`timescale 1ns/1ps
module unh_host_model
	import unh_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] host_input_word,
	output unh_host_pins_t host_pins
);
	initial host_pins = '0;
	// Bounded poll, so a dead port cannot hang the host
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		while (host_input_word[b] !== v && n < 60) begin
			@(posedge clk);
			n++;
		end
	endtask
	// Byte out: data settles before the request rises
	task automatic send(input logic [7:0] d);
		@(posedge clk) host_pins.data <= d;
		@(posedge clk) host_pins.host_request <= 1'b1;
		poll(5, 1'b1);
		@(posedge clk) host_pins.host_request <= 1'b0;
	endtask
	// Byte in: high nibble first, then low, then acknowledge
	task automatic fetch(output logic [7:0] d);
		poll(4, 1'b0);
		@(posedge clk) host_pins.nibble_select <= 1'b0;
		repeat (8) @(posedge clk);
		d[7:4] = host_input_word[3:0];
		@(posedge clk) host_pins.nibble_select <= 1'b1;
		repeat (8) @(posedge clk);
		d[3:0] = host_input_word[3:0];
		@(posedge clk) host_pins.host_acknowledge <= 1'b1;
		poll(4, 1'b1);
		@(posedge clk) host_pins.host_acknowledge <= 1'b0;
	endtask
endmodule

// >>> tb/umbilical_nibble_handshake_test.sv
// Self-checking bench for the umbilical handshake port
`timescale 1ns/1ps
module umbilical_nibble_handshake_test
	import unh_pkg::*;
;
	logic clk, rst, reg_write, reg_read, irq;
	logic rd_d = 1'b0;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, hiw, b, got;
	logic [7:0] expq[$];
	integer seed;
	unh_host_pins_t hp;
	int miscompares = 0;
	int compares = 0;
	unh_port dut (.clk(clk), .rst(rst), .host_pins(hp),
		.host_input_word(hiw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.irq(irq));
	unh_host_model host (.clk(clk), .host_input_word(hiw), .host_pins(hp));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic check(input string w, input logic [7:0] e, s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// Expected data is queued; the monitor pops it two cycles later
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		expq.push_back(e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
	endtask
	always @(posedge clk) begin
		if (rd_d) check("reg_rdata", expq.pop_front(), reg_rdata);
		rd_d <= reg_read;
	end
	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog well beyond two rounds of traffic
	initial begin
		#300us;
		miscompares++;
		tally_and_finish;
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h6D4C1595;
		rst = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		check("reset word", UNH_HIW_RST, hiw);
		for (int i = 0; i < 2; i++) begin
			b = 8'($random(seed));
			host.send(b);
			repeat (3) @(posedge clk);
			check("irq set", 8'h01, {7'h00, irq});
			check("ack high", 8'h01, {7'h00, hiw[5]});
			rd(UNH_REG_STATUS, 8'h05);
			rd(UNH_REG_RX_DATA, b);
			wr(UNH_REG_STATUS, 8'h0C);
			@(posedge clk); // Let the flag clear settle
			host.poll(5, 1'b0);
			check("ack low", 8'h00, {7'h00, hiw[5]});
			check("irq clear", 8'h00, {7'h00, irq});
			b = 8'($random(seed));
			wr(UNH_REG_TX_DATA, b);
			rd(UNH_REG_TX_DATA, b);
			rd(UNH_REG_STATUS, 8'h02);
			host.fetch(got);
			check("nibbles", b, got);
			check("req released", 8'h10, hiw & 8'h30);
			rd(UNH_REG_STATUS, 8'h08);
			wr(UNH_REG_STATUS, 8'h0C);
			rd(4'hF, 8'h00);
			$display("Test round %0d done", i);
		end
		repeat (4) @(posedge clk);
		tally_and_finish;
	end
endmodule
